/* File: rtl/qsmd_cfg.svh */
// Operation
// - dword 23 bits 31:24 hold quad-instruction DTR opcode
// - bits 23:21 hold mode clocks, zero if none
// - one DTR quad mode clock carries eight bits
// - bits 20:16 hold dummy clocks, zero if none
// - dummy clock count should be above zero
// - bits 15:8 hold single-lane-instruction DTR opcode
// - bits 7:5 hold its mode clock count
// - bits 4:0 hold its dummy clock count
// - sector map table provided for mixed sectors
// - region is contiguous same-size same-erase sectors
// - header length field counts dwords from one
// - header holds major and minor revision bytes
// - identifier split across both header dwords
// - table start pointer is dword-aligned byte address
// - command descriptors precede map descriptors
// - over two configurations need several command descriptors
// - command descriptor is two dwords of fields
// - detection command returns one byte, no mode
`ifndef QSMD_CFG_SVH
`define QSMD_CFG_SVH
`define QSMD_OFS_CTRL      8'h00
`define QSMD_OFS_QREAD     8'h04
`define QSMD_OFS_CFGSEL    8'h08
`define QSMD_OFS_STATUS    8'h0C
`define QSMD_CTRL_RST      32'h0000_0801
`define QSMD_QREAD_RST     32'hEE22_ED22
`define QSMD_CFGSEL_RST    8'h00
`define QSMD_OP_PRM_RD     8'h5A
`define QSMD_OP_CFG_RD     8'h65
`define QSMD_PRM_DUMMY     5'h08
`define QSMD_BASIC_IDX     5'h16
`define QSMD_HDR_IDX       5'h17
`define QSMD_MAP_IDX       5'h19
`define QSMD_MAP_LEN       8'h0C
`define QSMD_MAP_MAJOR     8'h01
`define QSMD_MAP_MINOR     8'h00
`define QSMD_ID_LSB        8'h5C
`define QSMD_ID_MSB        8'h3A
`define QSMD_MAP_PTR       24'h00_0064
`define QSMD_CMD_ALEN      2'h1
`define QSMD_CMD_RSVD      2'h3
`define QSMD_REGION_DW     32'h0003_FFF4
`define QSMD_NUM_CFG       4
`endif

/* File: rtl/qsmd_pkg.sv */
package qsmd_pkg;
  typedef struct packed {
    logic [7:0] instr4;
    logic [2:0] mode4;
    logic [4:0] dummy4;
    logic [7:0] instr1;
    logic [2:0] mode1;
    logic [4:0] dummy1;
  } qsmd_qread_s;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic       mosi;
  } qsmd_link_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INSTR,
    ST_ADDR,
    ST_WAIT,
    ST_DATA,
    ST_IGNORE
  } qsmd_state_e;
endpackage : qsmd_pkg

/* File: rtl/qsmd_top.sv */
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "qsmd_cfg.svh"
module qsmd_top
  import qsmd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        link_sck,
  input  wire logic        link_cs_n,
  input  wire logic [3:0]  link_io_in,
  output logic      [3:0]  link_io_out,
  output logic      [3:0]  link_io_oe
);

  qsmd_link_s   raw;
  qsmd_link_s   s1_r;
  qsmd_link_s   s2_r;
  logic         sck_d_r;
  logic         rise;
  logic         fall;
  logic         cs_act;

  logic [31:0]  ctrl_r;
  qsmd_qread_s  qread_r;
  logic [7:0]   cfgsel_r;
  logic [7:0]   cmd_cnt_r;
  logic [7:0]   last_op_r;

  logic         wr_pend_r;
  logic [7:0]   wr_ofs_r;
  logic         ahb_go;
  logic [31:0]  rd_val;

  qsmd_state_e  st_r;
  logic [4:0]   cnt_r;
  logic [7:0]   sh_r;
  logic [7:0]   op_r;
  logic [23:0]  addr_r;
  logic [7:0]   ob_r;
  logic [2:0]   bcnt_r;
  logic         dout_r;
  logic         oe_r;
  logic [4:0]   wait_len;
  logic [7:0]   instr_in;
  logic [23:0]  addr_in;

  logic [31:0]  ptab [0:31];

  // link pins cross into hclk through two flops each
  assign raw = '{sck: link_sck, cs_n: link_cs_n, mosi: link_io_in[0]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r    <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      s2_r    <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      sck_d_r <= 1'b0;
    end
    else if (ce)
    begin
      s1_r    <= raw;
      s2_r    <= s1_r;
      sck_d_r <= s2_r.sck;
    end
  end

  assign cs_act = !s2_r.cs_n && ctrl_r[0];
  assign rise   = cs_act && s2_r.sck && !sck_d_r;
  assign fall   = cs_act && !s2_r.sck && sck_d_r;

  // parameter space: basic table, map header, sector map table
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      ptab[i] = 32'h0000_0000;
    ptab[`QSMD_BASIC_IDX] = qread_r;
    ptab[`QSMD_HDR_IDX] = {`QSMD_MAP_LEN, `QSMD_MAP_MAJOR,
                           `QSMD_MAP_MINOR, `QSMD_ID_LSB};
    ptab[`QSMD_HDR_IDX + 5'h1] = {`QSMD_ID_MSB, `QSMD_MAP_PTR};
    // two detection descriptors select among four maps, ahead of the maps
    for (int c = 0; c < 2; c++)
    begin
      ptab[`QSMD_MAP_IDX + 5'(2 * c)] = {8'(8'h01 << c), `QSMD_CMD_ALEN,
                                         `QSMD_CMD_RSVD, ctrl_r[11:8],
                                         `QSMD_OP_CFG_RD, 6'h3F, 1'b0, 1'(c)};
      ptab[`QSMD_MAP_IDX + 5'(2 * c + 1)] = 32'h0000_0000;
    end
    // words past the last stored index are dropped, never wrapped to the bottom
    for (int m = 0; m < `QSMD_NUM_CFG; m++)
    begin
      if (`QSMD_MAP_IDX + 4 + 2 * m < 32)
        ptab[`QSMD_MAP_IDX + 4 + 2 * m] = {16'h0000, 8'(m), 6'h3F, 1'b1,
                                           1'(m == `QSMD_NUM_CFG - 1)};
      if (`QSMD_MAP_IDX + 5 + 2 * m < 32)
        ptab[`QSMD_MAP_IDX + 5 + 2 * m] = `QSMD_REGION_DW;
    end
  end

  function automatic logic [7:0] byte_at(input logic [7:0] op, input logic [23:0] a,
                                         input logic [7:0] sel);
    logic [31:0] w;
    w = ptab[a[6:2]];
    if (op == `QSMD_OP_CFG_RD)
      byte_at = sel;
    else if (a[23:7] != 17'h0)
      byte_at = 8'h00;
    else
      byte_at = w[8 * a[1:0] +: 8];
  endfunction : byte_at

  // detection command latency is software programmable, parameter read is fixed
  assign wait_len = (op_r == `QSMD_OP_CFG_RD) ? {1'b0, ctrl_r[11:8]} : `QSMD_PRM_DUMMY;
  assign instr_in = {sh_r[6:0], s2_r.mosi};
  assign addr_in  = {addr_r[22:0], s2_r.mosi};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r   <= ST_IDLE;
      cnt_r  <= 5'h00;
      sh_r   <= 8'h00;
      op_r   <= 8'h00;
      addr_r <= 24'h00_0000;
      ob_r   <= 8'h00;
      bcnt_r <= 3'h0;
    end
    else if (ce)
    begin
      if (!cs_act)
      begin
        st_r  <= ST_IDLE;
        cnt_r <= 5'h00;
      end
      else
      begin
        case (st_r)
          ST_IDLE:
          begin
            st_r  <= ST_INSTR;
            cnt_r <= 5'h00;
          end
          ST_INSTR:
            if (rise)
            begin
              sh_r  <= instr_in;
              cnt_r <= cnt_r + 5'h01;
              if (cnt_r == 5'h07)
              begin
                op_r  <= instr_in;
                cnt_r <= 5'h00;
                if (instr_in == `QSMD_OP_PRM_RD || instr_in == `QSMD_OP_CFG_RD)
                  st_r <= ST_ADDR;
                else
                  st_r <= ST_IGNORE;
              end
            end
          ST_ADDR:
            if (rise)
            begin
              addr_r <= addr_in;
              cnt_r  <= cnt_r + 5'h01;
              if (cnt_r == 5'h17)
              begin
                cnt_r  <= 5'h00;
                bcnt_r <= 3'h0;
                if (wait_len == 5'h00)
                begin
                  st_r <= ST_DATA;
                  ob_r <= byte_at(op_r, addr_in, cfgsel_r);
                end
                else
                  st_r <= ST_WAIT;
              end
            end
          ST_WAIT:
            // lanes stay released by the device until the falling edge of the last wait clock
            if (rise)
            begin
              cnt_r <= cnt_r + 5'h01;
              if (cnt_r == wait_len - 5'h01)
              begin
                st_r <= ST_DATA;
                ob_r <= byte_at(op_r, addr_r, cfgsel_r);
              end
            end
          ST_DATA:
            if (fall)
            begin
              bcnt_r <= bcnt_r + 3'h1;
              ob_r   <= {ob_r[6:0], 1'b0};
              if (bcnt_r == 3'h7)
              begin
                addr_r <= addr_r + 24'h00_0001;
                ob_r   <= byte_at(op_r, addr_r + 24'h00_0001, cfgsel_r);
              end
            end
          ST_IGNORE:
            st_r <= ST_IGNORE;
          default:
            st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // serial output changes on falling link clock, stays driven until deselect
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dout_r <= 1'b0;
      oe_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (!cs_act)
        oe_r <= 1'b0;
      else if (fall && st_r == ST_DATA)
      begin
        dout_r <= ob_r[7];
        oe_r   <= 1'b1;
      end
    end
  end

  assign link_io_out = {2'b00, dout_r, 1'b0};
  assign link_io_oe  = {2'b00, oe_r, 1'b0};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_cnt_r <= 8'h00;
      last_op_r <= 8'h00;
    end
    else if (ce && st_r == ST_INSTR && rise && cnt_r == 5'h07)
    begin
      cmd_cnt_r <= cmd_cnt_r + 8'h01;
      last_op_r <= instr_in;
    end
  end

  // bus slave: zero wait states, writes land in the data phase
  assign ahb_go    = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb
  begin
    case (haddr[7:0])
      `QSMD_OFS_CTRL:   rd_val = ctrl_r;
      `QSMD_OFS_QREAD:  rd_val = qread_r;
      `QSMD_OFS_CFGSEL: rd_val = {24'h00_0000, cfgsel_r};
      `QSMD_OFS_STATUS: rd_val = {8'h00, cmd_cnt_r, last_op_r, 5'h00, st_r == ST_DATA,
                                  oe_r, cs_act};
      default:          rd_val = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000)
      rd_val = 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wr_pend_r <= ahb_go && hwrite && haddr[31:8] == 24'h00_0000;
      wr_ofs_r  <= haddr[7:0];
      if (ahb_go && !hwrite)
        hrdata <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r   <= `QSMD_CTRL_RST;
      qread_r  <= `QSMD_QREAD_RST;
      cfgsel_r <= `QSMD_CFGSEL_RST;
    end
    else if (ce && wr_pend_r)
    begin
      case (wr_ofs_r)
        `QSMD_OFS_CTRL:   ctrl_r   <= {20'h0_0000, hwdata[11:8], 7'h00, hwdata[0]};
        `QSMD_OFS_QREAD:  qread_r  <= hwdata;
        `QSMD_OFS_CFGSEL: cfgsel_r <= hwdata[7:0];
        default:          ctrl_r   <= ctrl_r;
      endcase
    end
  end

endmodule : qsmd_top

/* File: dv/qsmd_top_monitor.sv */
`timescale 1ns/1ps
module qsmd_top_monitor
  import qsmd_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        link_cs_n,
  input wire logic [3:0]  link_io_out,
  input wire logic [3:0]  link_io_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_take = hsel && htrans[1] && hready && !hwrite && ce;
  sequence s_cs_idle;
    link_cs_n [*6];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_lane_one: assert property ((link_io_oe & 4'hD) == 4'h0 && (link_io_out & 4'hD) == 4'h0)
    else $error("unused lane driven");
  a_oe_release: assert property (s_cs_idle |-> !link_io_oe[1])
    else $error("lane driven outside frame");
  a_oe_late: assert property ($rose(link_io_oe[1]) |-> !link_cs_n && !$past(link_cs_n, 8))
    else $error("lane driven too early");
  a_oe_hold: assert property (link_io_oe[1] && !link_cs_n |=> link_io_oe[1])
    else $error("lane released mid frame");
  a_rdata_hold: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved");
  a_ce_freeze: assert property (!ce |=> $stable(link_io_oe) && $stable(hrdata))
    else $error("state moved while frozen");
  a_reset_vals: assert property ($rose(hresetn) |-> hrdata == 32'h0 && link_io_oe == 4'h0)
    else $error("outputs wrong after reset");
endmodule : qsmd_top_monitor
bind qsmd_top qsmd_top_monitor qsmd_top_monitor_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .link_cs_n(link_cs_n), .link_io_out(link_io_out),
  .link_io_oe(link_io_oe));

/* File: dv/qsmd_host_model.sv */
`timescale 1ns/1ps
module qsmd_host_model
(
  output logic            link_sck,
  output logic            link_cs_n,
  output logic      [3:0] link_io_in,
  input  wire logic [3:0] link_io_out,
  input  wire logic [3:0] link_io_oe
);
  event       got;
  logic [7:0] got_byte;
  logic       oe_any;
  initial
  begin
    link_sck   = 1'b0;
    link_cs_n  = 1'b1;
    link_io_in = 4'hA;
  end
  // one frame: 8 op bits, 3 address bytes, w wait clocks, n data bytes
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int w, input int n);
    logic [31:0] h;
    logic        s;
    h = {op, a};
    oe_any = 1'b0;
    // keep link edges off the hclk edges
    #7;
    link_cs_n = 1'b0;
    for (int i = 0; i < 32 + w + 8 * n; i++)
    begin
      link_io_in = (i < 32) ? {~link_io_in[3:1], h[31 - i]} : 4'hF;
      #160;
      link_sck = 1'b1;
      #159;
      // an undriven lane reads as the inverse of its last value
      s = link_io_oe[1] ? link_io_out[1] : ~link_io_out[1];
      oe_any = oe_any | link_io_oe[1];
      #1;
      link_sck = 1'b0;
      if (i >= 32 + w)
      begin
        got_byte = {got_byte[6:0], s};
        if ((i - 32 - w) % 8 == 7)
          -> got;
      end
    end
    #160;
    link_cs_n = 1'b1;
    #160;
  endtask : frame
endmodule : qsmd_host_model

/* File: dv/qsmd_top_bench.sv */
`timescale 1ns/1ps
`include "qsmd_cfg.svh"
module qsmd_top_bench;
  import qsmd_pkg::*;
  typedef struct {string n; logic [31:0] v;} qsmd_exp_s;
  logic        hclk, hresetn, ce, hsel, hwrite, rd_dp, hreadyout, hresp, link_sck, link_cs_n;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  link_io_in, link_io_out, link_io_oe;
  logic [7:0]  sel_r, sel_v;
  qsmd_exp_s   exp_q[$];
  int          fail_count, checks_done, seed;
  qsmd_top qsmd_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_sck(link_sck),
    .link_cs_n(link_cs_n), .link_io_in(link_io_in), .link_io_out(link_io_out),
    .link_io_oe(link_io_oe));
  qsmd_host_model qsmd_host_model_inst (.link_sck(link_sck), .link_cs_n(link_cs_n),
    .link_io_in(link_io_in), .link_io_out(link_io_out), .link_io_oe(link_io_oe));
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic finish_test;
    if (exp_q.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic take(input logic [31:0] seen);
    qsmd_exp_s e;
    e = exp_q.pop_front();
    checks_done++;
    if (seen !== e.v)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", e.n, e.v, seen);
    end
  endtask : take
  always @(posedge hclk)
  begin
    if (rd_dp === 1'b1)
      take(hrdata);
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout && ce;
  end
  always @(qsmd_host_model_inst.got) take({24'h0, qsmd_host_model_inst.got_byte});
  task automatic wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (k >= 16)
    begin
      fail_count++;
      finish_test;
    end
  endtask : wait_rdy
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, input string n);
    @(posedge hclk);
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    if (!wr)
      exp_q.push_back('{n, d});
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask : ahb
  task automatic exp_dw(input logic [31:0] d);
    for (int i = 0; i < 32; i += 8)
      exp_q.push_back('{"link byte", {24'h0, d[i+:8]}});
  endtask : exp_dw
  function automatic logic [31:0] desc(input logic [7:0] m, input logic [3:0] l, input logic e);
    return {m, 2'b01, 2'b11, l, `QSMD_OP_CFG_RD, 6'h3F, 1'b0, e};
  endfunction : desc
  initial
  begin
    {hresetn, hwrite, rd_dp, ce, hsel} = 5'b00011;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    {fail_count, checks_done, seed} = {32'h0, 32'h0, 32'h248DE744};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h00, `QSMD_CTRL_RST, "ctrl");
    ahb(1'b0, 32'h04, `QSMD_QREAD_RST, "qread");
    ahb(1'b0, 32'h08, 32'h0, "cfgsel");
    ahb(1'b0, 32'h10, 32'h0, "unmapped");
    ahb(1'b0, 32'h100, 32'h0, "outside");
    rv = $random(seed);
    ahb(1'b1, 32'h04, rv, "");
    ahb(1'b0, 32'h04, rv, "qread");
    exp_dw(rv);
    exp_dw({`QSMD_MAP_LEN, `QSMD_MAP_MAJOR, `QSMD_MAP_MINOR, `QSMD_ID_LSB});
    exp_dw({`QSMD_ID_MSB, `QSMD_MAP_PTR});
    qsmd_host_model_inst.frame(`QSMD_OP_PRM_RD, 24'h58, 8, 12);
    for (int i = 1; i <= 2; i++)
    begin
      exp_dw(desc(8'(i), 4'h8, i == 2));
      exp_dw(32'h0);
    end
    qsmd_host_model_inst.frame(`QSMD_OP_PRM_RD, `QSMD_MAP_PTR, 8, 16);
    sel_r = 8'($random(seed));
    ahb(1'b1, 32'h08, {24'h0, sel_r}, "");
    ahb(1'b1, 32'h00, 32'h0301, "");
    sel_v = 8'h00;
    for (int i = 0; i < 2; i++)
    begin
      exp_q.push_back('{"cfg byte", {24'h0, sel_r}});
      qsmd_host_model_inst.frame(`QSMD_OP_CFG_RD, 24'h0, 3, 1);
      sel_v = {sel_v[6:0], |(qsmd_host_model_inst.got_byte & (8'h01 << i))};
    end
    exp_q.push_back('{"selector", {30'h0, sel_r[0], sel_r[1]}});
    take({24'h0, sel_v});
    exp_dw(desc(8'h01, 4'h3, 1'b0));
    qsmd_host_model_inst.frame(`QSMD_OP_PRM_RD, `QSMD_MAP_PTR, 8, 4);
    ahb(1'b0, 32'h0C, 32'h0005_5A00, "status");
    exp_dw(32'h0);
    qsmd_host_model_inst.frame(`QSMD_OP_PRM_RD, 24'h0, 8, 4);
    for (int i = 0; i < 2; i++)
    begin
      if (i == 1)
        ahb(1'b1, 32'h00, 32'h0300, "");
      qsmd_host_model_inst.frame(i ? `QSMD_OP_PRM_RD : 8'h03, 24'h0, 16, 0);
      exp_q.push_back('{"ignored oe", 32'h0});
      take({31'h0, qsmd_host_model_inst.oe_any});
    end
    ce <= 1'b0;
    ahb(1'b1, 32'h08, {24'h0, ~sel_r}, "");
    ce <= 1'b1;
    ahb(1'b0, 32'h08, {24'h0, sel_r}, "cfgsel");
    @(posedge hclk);
    finish_test;
  end
  initial
  begin
    #1000000;
    fail_count++;
    finish_test;
  end
endmodule : qsmd_top_bench
